// File: inc/pwm_timer_pkg.sv
// Purpose: constants and types for the 16-bit timer pulse width modulation block
// Assumes: AXI4-Lite register access, 32-bit data, one clock
// Notes: offsets are byte addresses
`default_nettype none
package pwm_timer_pkg;
  // ********************
  // register map
  // ********************
  localparam logic [7:0] CTRL_ONE_OFS = 8'h00;
  localparam logic [7:0] CTRL_TWO_OFS = 8'h04;
  localparam logic [7:0] PULSE_HI_OFS = 8'h08;
  localparam logic [7:0] PULSE_LO_OFS = 8'h0C;
  localparam logic [7:0] PERIOD_HI_OFS = 8'h10;
  localparam logic [7:0] PERIOD_LO_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam logic [7:0] MASK_OFS = 8'h1C;
  localparam logic [7:0] COUNT_OFS = 8'h20;
  localparam logic [7:0] CAPTURE_OFS = 8'h24;
  // ********************
  // fields and reset values
  // ********************
  localparam int PULSE_LVL_BIT = 0;
  localparam int PERIOD_LVL_BIT = 1;
  localparam int CAP_IE_BIT = 2;
  localparam int CLK_SEL_LSB = 0;
  localparam int OUT_EN_BIT = 2;
  localparam int PWM_BIT = 3;
  localparam int ONE_PULSE_BIT = 4;
  localparam int CAP_ONE_BIT = 0;
  localparam int CAP_TWO_BIT = 1;
  localparam int CMP_ONE_BIT = 2;
  localparam int CMP_TWO_BIT = 3;
  localparam logic [15:0] RELOAD_VALUE = 16'hFFFC;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  localparam logic [2:0] DIV2_MASK = 3'h1;
  localparam logic [2:0] DIV4_MASK = 3'h3;
  localparam logic [2:0] DIV8_MASK = 3'h7;

  typedef struct packed {
    logic one_pulse;
    logic pwm_on;
    logic out_en;
    logic [1:0] clk_sel;
  } ctrl_two_s;
endpackage
`default_nettype wire

// File: sim/test_pwm_timer.sv
// Purpose: self-checking bench for the pulse width modulation timer
// Assumes: 50 MHz aclk, bench acts as AXI4-Lite master, ext_clk runs at aclk/6
// Notes: pulse compare 0x0010, period compare 0x0030; widths counted in aclk cycles
`default_nettype none
module test_pwm_timer;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [1:0] sel;
    logic [15:0] hi;
    logic [15:0] per;
  } row_s;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic ext_clk = 1'b0, cap1 = 1'b0, cap2 = 1'b0, pin_q = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin, owned, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  int error_cnt = 0, checked = 0, cyc = 0, ext_n = 0, toggles = 0, t0, hi, per;
  // high width is 0x20 ticks, period 0x30 + 5 ticks; ext tick every 6 cycles
  row_s rows [4] = '{
    '{pwm_timer_pkg::CLK_DIV4, 16'h0080, 16'h00D4},
    '{pwm_timer_pkg::CLK_DIV8, 16'h0100, 16'h01A8},
    '{pwm_timer_pkg::CLK_EXT, 16'h00C0, 16'h013E},
    '{pwm_timer_pkg::CLK_DIV2, 16'h0040, 16'h006A}};
  logic [7:0] rst_regs [5] = '{pwm_timer_pkg::CTRL_TWO_OFS, pwm_timer_pkg::STATUS_OFS,
    pwm_timer_pkg::MASK_OFS, pwm_timer_pkg::PULSE_LO_OFS, pwm_timer_pkg::PERIOD_LO_OFS};

  pwm_timer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_clk(ext_clk), .capture_one_pin(cap1), .capture_two_pin(cap2),
    .modulated_output_pin(pin), .pin_owned(owned), .irq(irq));

  initial begin
    forever #10 aclk = ~aclk;
  end

  // ********************
  // timeout, external clock, toggle monitor
  // ********************
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    ext_n <= (ext_n == 5) ? 0 : ext_n + 1;
    ext_clk <= (ext_n < 3);
    pin_q <= pin;
    if (pin_q !== pin) toggles++;
    if (cyc == 40000) begin
      error_cnt++;
      results();
    end
  end

  // ********************
  // tasks
  // ********************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks=%0d errors=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // entry edge first, so a strobe is never assigned twice in one time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_p, w_p;
    @(posedge aclk);
    aw_p = 1'b1;
    w_p = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge aclk);
      if (aw_p && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wpin(input logic v);
    while (pin !== v) @(posedge aclk);
  endtask

  // skips to a clean rise, then counts one high phase and one whole period
  task automatic meas;
    wpin(1'b0);
    wpin(1'b1);
    hi = 0;
    per = 0;
    while (pin === 1'b1) begin
      hi++;
      per++;
      @(posedge aclk);
    end
    while (pin === 1'b0) begin
      per++;
      @(posedge aclk);
    end
  endtask

  // raises one capture pin for two cycles; a one picks pin two
  task automatic pulse(input bit two);
    if (two) cap2 <= 1'b1;
    else cap1 <= 1'b1;
    repeat (2) @(posedge aclk);
    cap1 <= 1'b0;
    cap2 <= 1'b0;
  endtask

  // ********************
  // main sequence
  // ********************
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    wr(pwm_timer_pkg::PULSE_HI_OFS, 32'h0000_0000);
    wr(pwm_timer_pkg::PULSE_LO_OFS, 32'h0000_0010);
    wr(pwm_timer_pkg::PERIOD_HI_OFS, 32'h0000_0000);
    wr(pwm_timer_pkg::PERIOD_LO_OFS, 32'h0000_0030);
    wr(pwm_timer_pkg::CTRL_ONE_OFS, 32'h0000_0005);
    wr(pwm_timer_pkg::MASK_OFS, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      wr(pwm_timer_pkg::CTRL_TWO_OFS, {28'h0000_000, 2'h3, rows[i].sel});
      meas();
      check(hi, rows[i].hi);
      check(per, rows[i].per);
      check(owned, 1'b1);
    end
    check(irq, 1'b1);
    rdr(pwm_timer_pkg::STATUS_OFS);
    check(rd & 32'h0000_000F, 32'h0000_0001);
    check(rsp, pwm_timer_pkg::RESP_OKAY);
    wr(pwm_timer_pkg::MASK_OFS, 32'h0000_0000);
    repeat (3) @(posedge aclk);
    check(irq, 1'b0);
    wr(pwm_timer_pkg::MASK_OFS, 32'h0000_0001);
    // write lands in the low phase, so the running period must keep its edge
    wpin(1'b0);
    wr(pwm_timer_pkg::PULSE_LO_OFS, 32'h0000_0028);
    meas();
    check(hi, 32'h0000_0040);
    meas();
    check(hi, 32'h0000_0010);
    wpin(1'b0);
    wr(pwm_timer_pkg::PULSE_HI_OFS, 32'h0000_0000);
    t0 = toggles;
    repeat (300) @(posedge aclk);
    check(toggles - t0, 0);
    wr(pwm_timer_pkg::PULSE_LO_OFS, 32'h0000_0010);
    meas();
    meas();
    check(hi, 32'h0000_0040);
    wr(pwm_timer_pkg::CTRL_TWO_OFS, 32'h0000_001D);
    meas();
    check(hi, 32'h0000_0040);
    wr(pwm_timer_pkg::CTRL_ONE_OFS, 32'h0000_0007);
    repeat (120) @(posedge aclk);
    t0 = toggles;
    repeat (300) @(posedge aclk);
    check(toggles - t0, 0);
    check(pin, 1'b1);
    wr(pwm_timer_pkg::CTRL_TWO_OFS, 32'h0000_0019);
    repeat (3) @(posedge aclk);
    check(owned, 1'b0);
    wr(pwm_timer_pkg::STATUS_OFS, 32'h0000_000F);
    pulse(1'b1);
    repeat (4) @(posedge aclk);
    rdr(pwm_timer_pkg::STATUS_OFS);
    check(rd & 32'h0000_000E, 32'h0000_0002);
    rdr(pwm_timer_pkg::CAPTURE_OFS);
    check(rd[15:0] <= 16'h0030 || rd[15:0] >= 16'hFFFC, 1'b1);
    // period compare held off, so only the capture pin could set bit 0
    wr(pwm_timer_pkg::PERIOD_HI_OFS, 32'h0000_0000);
    wr(pwm_timer_pkg::STATUS_OFS, 32'h0000_000F);
    pulse(1'b0);
    repeat (120) @(posedge aclk);
    rdr(pwm_timer_pkg::STATUS_OFS);
    check(rd & 32'h0000_0001, 32'h0000_0000);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    check({pin, owned, irq}, 3'h0);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rdr(rst_regs[i]);
      check(rd, 32'h0000_0000);
    end
    wr(8'h28, 32'h0000_00FF);
    check(rsp, pwm_timer_pkg::RESP_SLVERR);
    rdr(8'h28);
    check(rsp, pwm_timer_pkg::RESP_SLVERR);
    check(rd, 32'h0000_0000);
    results();
  end
endmodule // test_pwm_timer
`default_nettype wire

// File: verilog/pwm_timer.sv
// Purpose: pulse width modulation mode of a 16-bit free-running timer
// Assumes: AXI4-Lite slave, pins synchronous to aclk, 50 MHz clock
// Notes: status bits clear by writing one; irq is a level
//
// How it works
// - compare writes go to buffers, taken into use in pwm mode only at period end; outside pwm at once.
// - pulse compare match drives output to the pulse match level.
// - period compare match drives output to the period match level.
// - output pin used only with output enable; pwm bit activates mode.
// - levels high then low give positive pulse of period minus pulse.
// - equal levels keep the output constant.
// - clock select gives cpu clock over 2, 4 or 8, or external clock.
// - period match in pwm mode reloads the counter with FFFC.
// - high byte write inhibits that compare until low byte is written.
// - compare flags are never set while modulating.
// - period match sets capture one flag; interrupt if enabled.
// - capture one pin is ignored while modulating.
// - capture two pin still captures and flags while modulating.
// - pwm and one pulse both set means pwm only.
// - modulation takes the compare one function and period register.
`default_nettype none
module pwm_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_clk,
  input wire logic capture_one_pin,
  input wire logic capture_two_pin,
  output logic modulated_output_pin,
  output logic pin_owned,
  output logic irq
);
  // ********************
  // registers
  // ********************
  logic [2:0] ctrl_one_q;
  pwm_timer_pkg::ctrl_two_s ctrl_two_q;
  logic [15:0] pulse_buf_q, period_buf_q, pulse_act_q, period_act_q;
  logic pulse_inh_q, period_inh_q;
  logic [3:0] status_q, mask_q;
  logic [15:0] count_q, capture_two_value_q;
  logic [2:0] pre_q;
  logic ext_q, cap1_q, cap2_q;
  logic aw_q, w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // ********************
  // bus decode
  // ********************
  wire do_write = aw_q && w_q && !s_axi_bvalid;
  wire wr_ok = do_write && wstrb_q[0];
  wire wr_c1 = wr_ok && awaddr_q == pwm_timer_pkg::CTRL_ONE_OFS;
  wire wr_c2 = wr_ok && awaddr_q == pwm_timer_pkg::CTRL_TWO_OFS;
  wire wr_ph = wr_ok && awaddr_q == pwm_timer_pkg::PULSE_HI_OFS;
  wire wr_pl = wr_ok && awaddr_q == pwm_timer_pkg::PULSE_LO_OFS;
  wire wr_th = wr_ok && awaddr_q == pwm_timer_pkg::PERIOD_HI_OFS;
  wire wr_tl = wr_ok && awaddr_q == pwm_timer_pkg::PERIOD_LO_OFS;
  wire wr_st = wr_ok && awaddr_q == pwm_timer_pkg::STATUS_OFS;
  wire wr_mk = wr_ok && awaddr_q == pwm_timer_pkg::MASK_OFS;
  wire wr_known = awaddr_q inside {pwm_timer_pkg::CTRL_ONE_OFS, pwm_timer_pkg::CTRL_TWO_OFS,
    pwm_timer_pkg::PULSE_HI_OFS, pwm_timer_pkg::PULSE_LO_OFS, pwm_timer_pkg::PERIOD_HI_OFS,
    pwm_timer_pkg::PERIOD_LO_OFS, pwm_timer_pkg::STATUS_OFS, pwm_timer_pkg::MASK_OFS,
    pwm_timer_pkg::COUNT_OFS, pwm_timer_pkg::CAPTURE_OFS};
  wire [7:0] wbyte = wdata_q[7:0];

  logic [31:0] rd_mux;
  logic rd_known;
  always_comb begin
    rd_known = 1'b1;
    unique case (s_axi_araddr)
      pwm_timer_pkg::CTRL_ONE_OFS: rd_mux = {29'h0, ctrl_one_q};
      pwm_timer_pkg::CTRL_TWO_OFS: rd_mux = {27'h0, ctrl_two_q};
      pwm_timer_pkg::PULSE_HI_OFS: rd_mux = {24'h0, pulse_buf_q[15:8]};
      pwm_timer_pkg::PULSE_LO_OFS: rd_mux = {24'h0, pulse_buf_q[7:0]};
      pwm_timer_pkg::PERIOD_HI_OFS: rd_mux = {24'h0, period_buf_q[15:8]};
      pwm_timer_pkg::PERIOD_LO_OFS: rd_mux = {24'h0, period_buf_q[7:0]};
      pwm_timer_pkg::STATUS_OFS: rd_mux = {28'h0, status_q};
      pwm_timer_pkg::MASK_OFS: rd_mux = {28'h0, mask_q};
      pwm_timer_pkg::COUNT_OFS: rd_mux = {16'h0, count_q};
      pwm_timer_pkg::CAPTURE_OFS: rd_mux = {16'h0, capture_two_value_q};
      default: begin
        rd_mux = 32'h0;
        rd_known = 1'b0;
      end
    endcase
  end

  // ********************
  // timer clock and modes
  // ********************
  // pwm wins over one-pulse: one_pulse bit is only stored
  wire pwm_mode = ctrl_two_q.pwm_on;
  wire ext_rise = ext_q == 1'b0 && ext_clk == 1'b1;
  wire [1:0] csel = ctrl_two_q.clk_sel;
  wire tick = (csel == pwm_timer_pkg::CLK_DIV2 && (pre_q & pwm_timer_pkg::DIV2_MASK) == 3'h0)
    || (csel == pwm_timer_pkg::CLK_DIV4 && (pre_q & pwm_timer_pkg::DIV4_MASK) == 3'h0)
    || (csel == pwm_timer_pkg::CLK_DIV8 && (pre_q & pwm_timer_pkg::DIV8_MASK) == 3'h0)
    || (csel == pwm_timer_pkg::CLK_EXT && ext_rise);
  // compares evaluated on each step inhibited mid-write
  wire pulse_hit = tick && !pulse_inh_q && count_q == pulse_act_q;
  wire period_hit = tick && !period_inh_q && count_q == period_act_q;
  wire end_period = pwm_mode && period_hit;
  wire cap1_edge = !cap1_q && capture_one_pin && !pwm_mode;
  wire cap2_edge = !cap2_q && capture_two_pin;
  wire cmp1_ev = !pwm_mode && pulse_hit;
  wire cmp2_ev = !pwm_mode && period_hit;
  wire [3:0] ev = {cmp2_ev, cmp1_ev, cap2_edge, cap1_edge | end_period};
  wire [3:0] clr = wr_st ? wbyte[3:0] : 4'h0;

  // ********************
  // bus handshake
  // ********************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pwm_timer_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= pwm_timer_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? pwm_timer_pkg::RESP_OKAY : pwm_timer_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_known ? pwm_timer_pkg::RESP_OKAY : pwm_timer_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ********************
  // control and compare buffers
  // ********************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_one_q <= 3'h0;
      ctrl_two_q <= '0;
      pulse_buf_q <= pwm_timer_pkg::COMPARE_RESET;
      period_buf_q <= pwm_timer_pkg::COMPARE_RESET;
      pulse_inh_q <= 1'b0;
      period_inh_q <= 1'b0;
      mask_q <= pwm_timer_pkg::MASK_RESET;
    end else begin
      if (wr_c1) ctrl_one_q <= wbyte[2:0];
      if (wr_c2) ctrl_two_q <= wbyte[4:0];
      if (wr_mk) mask_q <= wbyte[3:0];
      if (wr_ph) begin
        pulse_buf_q[15:8] <= wbyte;
        pulse_inh_q <= 1'b1;
      end
      if (wr_pl) begin
        pulse_buf_q[7:0] <= wbyte;
        pulse_inh_q <= 1'b0;
      end
      if (wr_th) begin
        period_buf_q[15:8] <= wbyte;
        period_inh_q <= 1'b1;
      end
      if (wr_tl) begin
        period_buf_q[7:0] <= wbyte;
        period_inh_q <= 1'b0;
      end
    end
  end

  // ********************
  // counter, output and flags
  // ********************
  // active compares follow buffers outside pwm; in pwm only at period end,
  // so a new value never cuts a pulse short
  wire load_act = !pwm_mode || end_period;
  wire pulse_lvl = ctrl_one_q[pwm_timer_pkg::PULSE_LVL_BIT];
  wire period_lvl = ctrl_one_q[pwm_timer_pkg::PERIOD_LVL_BIT];
  logic out_d;
  always_comb begin
    out_d = modulated_output_pin;
    if (pwm_mode && pulse_hit) out_d = pulse_lvl;
    // period level last so it wins a same-step match
    if (end_period) out_d = period_lvl;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 3'h0;
      ext_q <= 1'b0;
      cap1_q <= 1'b0;
      cap2_q <= 1'b0;
      count_q <= pwm_timer_pkg::RELOAD_VALUE;
      pulse_act_q <= pwm_timer_pkg::COMPARE_RESET;
      period_act_q <= pwm_timer_pkg::COMPARE_RESET;
      capture_two_value_q <= 16'h0000;
      status_q <= 4'h0;
      modulated_output_pin <= 1'b0;
      pin_owned <= 1'b0;
      irq <= 1'b0;
    end else begin
      pre_q <= pre_q + 3'h1;
      ext_q <= ext_clk;
      cap1_q <= capture_one_pin;
      cap2_q <= capture_two_pin;
      if (end_period) count_q <= pwm_timer_pkg::RELOAD_VALUE;
      else if (tick) count_q <= count_q + 16'h0001;
      if (load_act) begin
        pulse_act_q <= pulse_buf_q;
        period_act_q <= period_buf_q;
      end
      if (cap2_edge) capture_two_value_q <= count_q;
      status_q <= (status_q & ~clr) | ev; // set wins over clear
      modulated_output_pin <= out_d;
      pin_owned <= ctrl_two_q.out_en;
      irq <= |(((status_q & ~clr) | ev) & mask_q
        & {3'h7, ctrl_one_q[pwm_timer_pkg::CAP_IE_BIT]});
    end
  end

  // ********************
  // checks
  // ********************
  a_period_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    end_period |=> count_q == pwm_timer_pkg::RELOAD_VALUE)
    else $error("period match did not reload counter");
  a_no_cmp_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(pwm_mode) |-> !$rose(status_q[3]) && !$rose(status_q[2]))
    else $error("compare flag set in pwm mode");
  a_cap_one_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    end_period |=> status_q[pwm_timer_pkg::CAP_ONE_BIT])
    else $error("capture one flag missing at period end");
  a_period_level: assert property (@(posedge aclk) disable iff (!aresetn)
    end_period |=> modulated_output_pin == $past(period_lvl))
    else $error("wrong level after period match");
  a_pulse_level: assert property (@(posedge aclk) disable iff (!aresetn)
    pwm_mode && pulse_hit && !period_hit |=> modulated_output_pin == $past(pulse_lvl))
    else $error("wrong level after pulse match");
  a_buffer_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    pwm_mode && !end_period |=> $stable(period_act_q) && $stable(pulse_act_q))
    else $error("active compare changed mid period");
  a_hi_inhibit: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_th && !wr_tl |=> !period_hit)
    else $error("period compare not inhibited after high byte");
  a_cap_two: assert property (@(posedge aclk) disable iff (!aresetn)
    cap2_edge |=> capture_two_value_q == $past(count_q) && status_q[1])
    else $error("capture two not taken");
  a_constant_out: assert property (@(posedge aclk) disable iff (!aresetn)
    pwm_mode && pulse_lvl == period_lvl && modulated_output_pin == pulse_lvl
      && $stable(ctrl_one_q) |=> $stable(modulated_output_pin))
    else $error("output toggled with equal levels");
  a_cap_one_off: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(pwm_mode) && !$past(end_period) && !$past(status_q[pwm_timer_pkg::CAP_ONE_BIT])
      |-> !status_q[pwm_timer_pkg::CAP_ONE_BIT])
    else $error("capture one pin acted in pwm mode");
  a_load_at_end: assert property (@(posedge aclk) disable iff (!aresetn)
    end_period |=> period_act_q == $past(period_buf_q) && pulse_act_q == $past(pulse_buf_q))
    else $error("buffers not taken at period end");
  a_pos_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    pwm_mode && pulse_lvl && !period_lvl && pulse_hit && !period_hit |=> modulated_output_pin)
    else $error("positive pulse did not start at pulse match");
  a_pulse_inhibit: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ph && !wr_pl |=> !pulse_hit)
    else $error("pulse compare not inhibited after high byte");
  a_out_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    !pwm_mode |=> $stable(modulated_output_pin))
    else $error("output moved outside pwm mode");
  a_owned_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_two_q.out_en |=> !pin_owned)
    else $error("pin owned without output enable");

  // ********************
  // checks on the timer clock and interrupt
  // ********************
  // prescaler is free-running, so any window of one divide mode as long as its divisor holds exactly one tick
  a_div2_rate: assert property (@(posedge aclk) disable iff (!aresetn)
    (csel == pwm_timer_pkg::CLK_DIV2) [*2] |-> tick != $past(tick))
    else $error("timer tick rate wrong for divide by 2");
  a_div4_rate: assert property (@(posedge aclk) disable iff (!aresetn)
    (csel == pwm_timer_pkg::CLK_DIV4) [*4]
      |-> $countones({tick, $past(tick), $past(tick, 2), $past(tick, 3)}) == 1)
    else $error("timer tick rate wrong for divide by 4");
  a_div8_rate: assert property (@(posedge aclk) disable iff (!aresetn)
    (csel == pwm_timer_pkg::CLK_DIV8) [*8]
      |-> $countones({tick, $past(tick), $past(tick, 2), $past(tick, 3), $past(tick, 4),
        $past(tick, 5), $past(tick, 6), $past(tick, 7)}) == 1)
    else $error("timer tick rate wrong for divide by 8");
  a_ext_tick: assert property (@(posedge aclk) disable iff (!aresetn)
    csel == pwm_timer_pkg::CLK_EXT |-> tick == (ext_clk && !$past(ext_clk)))
    else $error("external clock tick missed or extra");
  a_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && !end_period |=> count_q == $past(count_q) + 16'h0001)
    else $error("counter did not step on tick");
  a_count_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !tick |=> $stable(count_q))
    else $error("counter moved without tick");
  a_irq_on: assert property (@(posedge aclk) disable iff (!aresetn)
    status_q[pwm_timer_pkg::CAP_ONE_BIT] && mask_q[0] && ctrl_one_q[pwm_timer_pkg::CAP_IE_BIT]
      && !clr[0] |=> irq)
    else $error("interrupt missing for enabled capture one flag");
  a_irq_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (status_q & mask_q) == 4'h0 && ev == 4'h0 |=> !irq)
    else $error("interrupt raised with no unmasked flag");
endmodule // pwm_timer
`default_nettype wire
